// ==== hw/esp_frame_ctrl.sv ====
`default_nettype none
`include "esp_map.svh"
module esp_frame_ctrl
  import esp_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // dma side
  input  wire logic        dma_select_strobe,
  input  wire logic        dma_select_value,
  input  wire logic        dma_frame_end_strobe,
  // shifter side, same clock
  input  wire logic        tx_start,
  input  wire logic        tx_bit,
  input  wire esp_events_s ev_in,
  output logic             rx_bit,
  output logic             select_in,
  output esp_mode_e        port_mode,
  output esp_ctl_s         ctl_out,
  output logic             irq,
  // pins
  input  wire logic        sck_in,
  output logic             sck_out,
  output logic             sck_oe,
  input  wire logic        mosi_in,
  output logic             mosi_out,
  output logic             mosi_oe,
  input  wire logic        miso_in,
  output logic             miso_out,
  output logic             miso_oe,
  input  wire logic        ss_in,
  output logic             ss_out,
  output logic             ss_oe
);

  esp_ctl_s    ctl_reg;
  esp_events_s status_reg;
  esp_events_s mask_reg;
  logic        frame_end_flag_reg;
  logic        select_value_reg;
  logic        select_is_output_reg;
  logic [3:0]  edge_cnt_reg;
  logic        busy_reg;
  logic        sck_prev_reg;
  logic [3:0]  pins_sync;
  logic        sck_s;
  logic        mosi_s;
  logic        miso_s;
  logic        ss_s;

  logic        wr_en;
  logic        rd_en;
  logic        hit_cmd;
  logic        hit_ctl;
  logic        hit_stat;
  logic        hit_mask;
  logic        hit_aux;
  logic        hit_any;
  logic        trail_edge;
  logic        byte_done;
  logic        last_done;
  logic        master_tx;
  esp_events_s ev_all;
  esp_events_s irq_gate;
  logic [31:0] rdata_next;

  // ---------------------------------------------------------------
  // pin inputs cross into pclk through two flops
  esp_sync #(
    .W (4)
  ) u_pin_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       ({sck_in, mosi_in, miso_in, ss_in}),
    .q       (pins_sync)
  );

  assign sck_s  = pins_sync[3];
  assign mosi_s = pins_sync[2];
  assign miso_s = pins_sync[1];
  assign ss_s   = pins_sync[0];

  // ---------------------------------------------------------------
  // apb decode; zero wait states, so every access ends in one
  // access cycle
  assign hit_cmd  = (paddr == `ESP_ADDR(`ESP_CMD_IDX));
  assign hit_ctl  = (paddr == `ESP_ADDR(`ESP_CTL_IDX));
  assign hit_stat = (paddr == `ESP_ADDR(`ESP_STAT_IDX));
  assign hit_mask = (paddr == `ESP_ADDR(`ESP_MASK_IDX));
  assign hit_aux  = (paddr == `ESP_ADDR(`ESP_AUX_IDX));
  assign hit_any  = hit_cmd | hit_ctl | hit_stat | hit_mask | hit_aux;

  assign wr_en  = psel & penable & pwrite & hit_any;
  assign rd_en  = psel & penable & ~pwrite & hit_any;
  assign pready = 1'b1;
  // unmapped addresses answer with an error and no side effect
  assign pslverr = psel & penable & ~hit_any;

  // ---------------------------------------------------------------
  // port control: plain eight bit read-write register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_reg <= esp_ctl_s'(`ESP_CTL_RESET);
    end else if (wr_en && hit_ctl) begin
      ctl_reg <= esp_ctl_s'(pwdata[7:0]);
    end
  end

  assign ctl_out = ctl_reg;

  // enable pair bits sit at 6 and 0; their code is the mode
  assign port_mode = esp_mode_e'({ctl_reg.enable_pair_high,
                                  ctl_reg.enable_pair_low});

  // ---------------------------------------------------------------
  // select direction lives in an auxiliary register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      select_is_output_reg <= 1'b0;
    end else if (wr_en && hit_aux) begin
      select_is_output_reg <= pwdata[`ESP_AUX_SEL_OUT];
    end
  end

  // ---------------------------------------------------------------
  // byte tracking on the sampled serial clock.
  // the trailing edge of each bit cell is falling when the clock
  // idles low, rising when it idles high; eight of them end a byte
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sck_prev_reg <= 1'b0;
    end else begin
      sck_prev_reg <= sck_s;
    end
  end

  assign trail_edge = ctl_reg.clock_polarity ?
                      (sck_s & ~sck_prev_reg) :
                      (~sck_s & sck_prev_reg);

  assign master_tx = ctl_reg.master_enable &
                     ((port_mode == ESP_TX_ONLY) ||
                      (port_mode == ESP_TX_RX) ||
                      (port_mode == ESP_RX_ONLY));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_reg     <= 1'b0;
      edge_cnt_reg <= `ESP_CNT_RESET;
    end else if (!master_tx) begin
      // disabling the port drops a byte in flight
      busy_reg     <= 1'b0;
      edge_cnt_reg <= `ESP_CNT_RESET;
    end else if (tx_start && !busy_reg) begin
      busy_reg     <= 1'b1;
      edge_cnt_reg <= `ESP_CNT_RESET;
    end else if (busy_reg && trail_edge) begin
      if (edge_cnt_reg == `ESP_BITS_PER_BYTE - 4'h1) begin
        busy_reg     <= 1'b0;
        edge_cnt_reg <= `ESP_CNT_RESET;
      end else begin
        edge_cnt_reg <= edge_cnt_reg + 4'h1;
      end
    end
  end

  assign byte_done = busy_reg & trail_edge &
                     (edge_cnt_reg == `ESP_BITS_PER_BYTE - 4'h1);

  // only a master ends frames on its own
  assign last_done = byte_done & frame_end_flag_reg &
                     ctl_reg.master_enable;

  // ---------------------------------------------------------------
  // frame command: end-of-frame flag. a set from dma or bus in the
  // same cycle as the automatic clear wins, so no frame end is lost
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame_end_flag_reg <= `ESP_CMD_EOF_RESET;
    end else if (dma_frame_end_strobe) begin
      frame_end_flag_reg <= 1'b1;
    end else if (wr_en && hit_cmd) begin
      frame_end_flag_reg <= pwdata[`ESP_CMD_EOF_BIT];
    end else if (last_done) begin
      frame_end_flag_reg <= 1'b0;
    end
  end

  // select value: dma strobe beats a bus write, both beat the
  // toggle at frame end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      select_value_reg <= `ESP_CMD_SEL_RESET;
    end else if (dma_select_strobe) begin
      select_value_reg <= dma_select_value;
    end else if (wr_en && hit_cmd) begin
      select_value_reg <= pwdata[`ESP_CMD_SEL_BIT];
    end else if (last_done) begin
      select_value_reg <= ~select_value_reg;
    end
  end

  // ---------------------------------------------------------------
  // interrupt status: sticky, cleared by a read. only the bits the
  // read returned are cleared, so an event during the read survives
  always_comb begin
    ev_all            = ev_in;
    ev_all.frame_done = last_done;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_reg <= esp_events_s'(`ESP_EV_RESET);
    end else if (rd_en && hit_stat) begin
      status_reg <= (status_reg & ~esp_events_s'(prdata[6:0])) | ev_all;
    end else begin
      status_reg <= status_reg | ev_all;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_reg <= esp_events_s'(`ESP_EV_RESET);
    end else if (wr_en && hit_mask) begin
      mask_reg <= esp_events_s'(pwdata[6:0]);
    end
  end

  // data events pass only with the data enable; errors always pass
  always_comb begin
    irq_gate                  = mask_reg;
    irq_gate.tx_empty_flag    = mask_reg.tx_empty_flag &
                                ctl_reg.data_irq_enable;
    irq_gate.rx_full_flag     = mask_reg.rx_full_flag &
                                ctl_reg.data_irq_enable;
    irq_gate.tx_underrun_flag = mask_reg.tx_underrun_flag;
    irq_gate.collision_flag   = mask_reg.collision_flag;
    irq_gate.abort_flag       = mask_reg.abort_flag;
    irq_gate.rx_overrun_flag  = mask_reg.rx_overrun_flag;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status_reg & irq_gate);
    end
  end

  // ---------------------------------------------------------------
  // read data; reserved command bits always read zero
  always_comb begin
    rdata_next = 32'h0000_0000;
    if (hit_cmd) begin
      rdata_next[`ESP_CMD_EOF_BIT] = frame_end_flag_reg;
      rdata_next[`ESP_CMD_SEL_BIT] = select_value_reg;
    end else if (hit_ctl) begin
      rdata_next[7:0] = ctl_reg;
    end else if (hit_stat) begin
      rdata_next[6:0] = status_reg;
    end else if (hit_mask) begin
      rdata_next[6:0] = mask_reg;
    end else if (hit_aux) begin
      rdata_next[`ESP_AUX_SEL_OUT] = select_is_output_reg;
    end
  end

  // registered in the setup cycle so data is stable in access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rdata_next;
    end
  end

  // ---------------------------------------------------------------
  // pin drive. in wire-or mode a pin only ever pulls low.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sck_out <= 1'b0;
      sck_oe  <= 1'b0;
    end else begin
      // idle level of the clock follows polarity
      sck_out <= ctl_reg.clock_polarity;
      sck_oe  <= ctl_reg.master_enable &
                 (~ctl_reg.wire_or | ~ctl_reg.clock_polarity);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mosi_out <= 1'b0;
      mosi_oe  <= 1'b0;
      miso_out <= 1'b0;
      miso_oe  <= 1'b0;
    end else begin
      mosi_out <= tx_bit;
      miso_out <= tx_bit;
      mosi_oe  <= ctl_reg.master_enable &
                  (~ctl_reg.wire_or | ~tx_bit);
      miso_oe  <= ~ctl_reg.master_enable &
                  (port_mode != ESP_DISABLED) &
                  (~ctl_reg.wire_or | ~tx_bit);
    end
  end

  // data in is taken from the pin the master flag selects
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_bit    <= 1'b0;
      select_in <= 1'b0;
    end else begin
      rx_bit    <= ctl_reg.master_enable ? miso_s : mosi_s;
      select_in <= ss_s;
    end
  end

  // the stored select value reaches the pin only while it outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ss_out <= 1'b0;
      ss_oe  <= 1'b0;
    end else begin
      ss_out <= select_value_reg;
      ss_oe  <= select_is_output_reg & ctl_reg.master_enable &
                (~ctl_reg.wire_or | ~select_value_reg);
    end
  end

endmodule // esp_frame_ctrl
`default_nettype wire

// ==== hw/esp_map.svh ====
`ifndef ESP_MAP_SVH
`define ESP_MAP_SVH

`define ESP_ADDR(i)        ({6'h00, (i), 2'b00})
`define ESP_CMD_IDX        24'hFF_E261
`define ESP_CTL_IDX        24'hFF_E262
`define ESP_STAT_IDX       24'hFF_E270
`define ESP_MASK_IDX       24'hFF_E271
`define ESP_AUX_IDX        24'hFF_E272

`define ESP_CMD_SEL_BIT    0
`define ESP_CMD_EOF_BIT    1
`define ESP_CMD_RESET      8'h00
`define ESP_CMD_EOF_RESET  1'b0
`define ESP_CMD_SEL_RESET  1'b0
`define ESP_CTL_RESET      8'h00
`define ESP_EV_RESET       7'h00
`define ESP_AUX_SEL_OUT    0

`define ESP_BITS_PER_BYTE  4'h8
`define ESP_CNT_RESET      4'h0

`endif

// ==== hw/esp_pkg.sv ====
`default_nettype none
package esp_pkg;

  typedef enum logic [1:0] {
    ESP_DISABLED,
    ESP_RX_ONLY,
    ESP_TX_ONLY,
    ESP_TX_RX
  } esp_mode_e;

  typedef struct packed {
    logic data_irq_enable;
    logic enable_pair_high;
    logic baud_gen_control;
    logic phase;
    logic clock_polarity;
    logic wire_or;
    logic master_enable;
    logic enable_pair_low;
  } esp_ctl_s;

  typedef struct packed {
    logic frame_done;
    logic rx_overrun_flag;
    logic abort_flag;
    logic collision_flag;
    logic tx_underrun_flag;
    logic rx_full_flag;
    logic tx_empty_flag;
  } esp_events_s;

endpackage
`default_nettype wire

// ==== hw/esp_sync.sv ====
`default_nettype none
module esp_sync #(
  parameter int W = 1
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_reg;

  // first stage feeds only the second stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_reg <= '0;
      q        <= '0;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule // esp_sync
`default_nettype wire

// ==== tb/esp_frame_ctrl_sva.sv ====
`default_nettype none
`include "esp_map.svh"
module esp_frame_ctrl_sva
  import esp_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        dma_select_strobe,
  input wire logic        dma_select_value,
  input wire esp_ctl_s    ctl_out,
  input wire esp_mode_e   port_mode,
  input wire logic        sck_out,
  input wire logic        sck_oe,
  input wire logic        mosi_oe,
  input wire logic        miso_oe,
  input wire logic        ss_out,
  input wire logic        ss_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic acc;
  logic wr_ctl;
  logic wr_cmd;
  logic mst;
  assign acc = psel && penable && pwrite;
  assign wr_ctl = acc && paddr == `ESP_ADDR(`ESP_CTL_IDX);
  assign wr_cmd = acc && paddr == `ESP_ADDR(`ESP_CMD_IDX);
  // wire-or left out: there oe follows the driven level
  assign mst = ctl_out.master_enable && !ctl_out.wire_or;
  a_ctl_reset: assert property (
    $rose(presetn) |-> ctl_out == 8'h00)
    else $error("control not zero after reset");
  a_ctl_write: assert property (
    wr_ctl |=> ctl_out == $past(pwdata[7:0]))
    else $error("control write lost");
  a_mode_map: assert property (
    port_mode == esp_mode_e'({ctl_out[6], ctl_out[0]}))
    else $error("mode does not follow enable pair");
  a_master_pins: assert property (
    mst [*2] |-> sck_oe && mosi_oe && !miso_oe)
    else $error("master pin directions wrong");
  a_slave_pins: assert property (
    (!ctl_out.master_enable) [*2] |-> !sck_oe && !mosi_oe)
    else $error("slave drives clock or data out");
  a_sck_idle: assert property (
    (mst && port_mode == ESP_DISABLED && $stable(ctl_out)) [*2]
    |-> sck_out == ctl_out.clock_polarity)
    else $error("clock idle level wrong");
  a_bus_select: assert property (
    wr_cmd && ss_oe && !dma_select_strobe
    |-> ##2 ss_out == $past(pwdata[0], 2))
    else $error("select pin ignores bus write");
  a_dma_select: assert property (
    dma_select_strobe && ss_oe |-> ##2 ss_out == $past(dma_select_value, 2))
    else $error("select pin ignores dma");
  c_cmd_write: cover property (wr_cmd && ss_oe);
  c_full_mode: cover property (port_mode == ESP_TX_RX);
  c_dma_sel: cover property (dma_select_strobe && ss_oe);
endmodule // esp_frame_ctrl_sva

bind esp_frame_ctrl esp_frame_ctrl_sva esp_frame_ctrl_sva_i (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .dma_select_strobe, .dma_select_value, .ctl_out, .port_mode,
  .sck_out, .sck_oe, .mosi_oe, .miso_oe, .ss_out, .ss_oe
);
`default_nettype wire

// ==== tb/esp_link_model.sv ====
`default_nettype none
module esp_link_model (
  input  wire logic pol,
  output logic      sck,
  output logic      miso
);
  timeunit 1ns;
  timeprecision 1ps;
  logic busy;
  logic tgl;
  // clock stands still at its idle level outside frames
  assign sck = busy ? tgl ^ pol : pol;
  initial begin
    busy = 1'b0;
    tgl = 1'b0;
  end
  // released data line floats up to its pull-up level between frames
  assign miso = busy ? tgl : 1'b1;
  // odd start offset keeps the link out of phase with pclk
  task automatic frame;
    #37;
    busy = 1'b1;
    repeat (16) begin
      #100;
      tgl = ~tgl;
    end
    busy = 1'b0;
  endtask
endmodule // esp_link_model
`default_nettype wire

// ==== tb/tb_esp_frame_ctrl.sv ====
`default_nettype none
`include "esp_map.svh"
module tb_esp_frame_ctrl
  import esp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [23:0] CMD = `ESP_CMD_IDX;
  localparam logic [23:0] CTL = `ESP_CTL_IDX;
  localparam logic [23:0] STA = `ESP_STAT_IDX;
  localparam logic [23:0] MSK = `ESP_MASK_IDX;
  localparam logic [23:0] AUX = `ESP_AUX_IDX;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        dma_select_strobe;
  logic        dma_select_value;
  logic        dma_frame_end_strobe;
  logic        tx_start;
  logic        rx_bit;
  logic        select_in;
  logic        mosi_out;
  logic        miso_out;
  esp_events_s ev_in;
  esp_ctl_s    ctl_out;
  esp_mode_e   port_mode;
  logic        irq;
  logic        sck;
  logic        miso;
  logic        sck_out;
  logic        sck_oe;
  logic        mosi_oe;
  logic        miso_oe;
  logic        ss_out;
  logic        ss_oe;
  logic [31:0] r;
  logic [31:0] v;
  logic        serr;
  int          errors;
  int          checks;

  esp_frame_ctrl esp_frame_ctrl_i (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .dma_select_strobe, .dma_select_value,
    .dma_frame_end_strobe, .tx_start, .tx_bit(1'b1), .ev_in, .rx_bit,
    .select_in, .port_mode, .ctl_out, .irq, .sck_in(sck), .sck_out,
    .sck_oe, .mosi_in(1'b0), .mosi_out, .mosi_oe, .miso_in(miso),
    .miso_out, .miso_oe, .ss_in(1'b1), .ss_out, .ss_oe
  );
  esp_link_model esp_link_model_i (
    .pol(ctl_out.clock_polarity), .sck, .miso
  );

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %0t ns got %h expected %h", $time, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [23:0] i,
                     input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= `ESP_ADDR(i);
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [23:0] i, input logic [31:0] d);
    apb(1'b1, i, d);
    repeat (2) @(posedge pclk);
  endtask
  task automatic rd(input logic [23:0] i, input logic [31:0] e);
    apb(1'b0, i, 32'h0000_0000);
    chk(r, e);
  endtask
  task automatic strobe(input int k);
    dma_frame_end_strobe <= (k == 0);
    dma_select_strobe <= (k == 1);
    tx_start <= (k == 2);
    @(posedge pclk);
    {dma_frame_end_strobe, dma_select_strobe, tx_start} <= 3'b000;
    @(posedge pclk);
  endtask
  task automatic ev(input logic [6:0] e);
    ev_in <= e;
    @(posedge pclk);
    ev_in <= 7'h00;
    repeat (3) @(posedge pclk);
  endtask
  task automatic td(input string n);
    $display("test %s done", n);
  endtask
  task automatic end_of_test;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge pclk);
    errors++;
    end_of_test;
  end

  initial begin
    {presetn, psel, penable, pwrite, tx_start} = 5'b00000;
    {dma_select_strobe, dma_select_value, dma_frame_end_strobe} = 3'b000;
    {paddr, pwdata} = 64'h0000_0000_0000_0000;
    ev_in = 7'h00;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(CTL, 32'h0000_0000);
    rd(CMD, 32'h0000_0000);
    td("reset");
    for (int i = 0; i < 4; i++) begin
      v = {25'h000_0000, i[1], 5'h00, i[0]};
      wr(CTL, v);
      rd(CTL, v);
      chk(port_mode, i);
    end
    wr(CTL, 32'h0000_00BE);
    rd(CTL, 32'h0000_00BE);
    td("control");
    wr(CTL, 32'h0000_0002);
    chk({sck_oe, mosi_oe, miso_oe, sck_out}, 4'b1100);
    wr(CTL, 32'h0000_0008);
    chk({sck_oe, mosi_oe}, 2'b00);
    // slave: data in comes from the data-out line of the master
    chk({mosi_out, miso_out, rx_bit, select_in}, 4'b1101);
    wr(CTL, 32'h0000_000A);
    chk(sck_out, 1'b1);
    td("pins");
    wr(AUX, 32'h0000_0001);
    wr(CMD, 32'h0000_00FF);
    rd(CMD, 32'h0000_0003);
    chk({ss_oe, ss_out}, 2'b11);
    wr(CMD, 32'h0000_0000);
    chk(ss_out, 1'b0);
    wr(AUX, 32'h0000_0000);
    chk(ss_oe, 1'b0);
    td("command");
    wr(AUX, 32'h0000_0001);
    strobe(0);
    rd(CMD, 32'h0000_0002);
    dma_select_value <= 1'b1;
    strobe(1);
    rd(CMD, 32'h0000_0003);
    chk(ss_out, 1'b1);
    td("dma");
    // second pass runs with the flag clear, so select must hold
    wr(CTL, 32'h0000_0043);
    for (int f = 0; f < 2; f++) begin
      strobe(2);
      esp_link_model_i.frame();
      repeat (8) @(posedge pclk);
      rd(CMD, 32'h0000_0000);
      chk(ss_out, 1'b0);
      // master takes data in from the released, pulled-up line
      chk(rx_bit, 1'b1);
    end
    rd(STA, 32'h0000_0040);
    td("frame");
    wr(MSK, 32'h0000_007F);
    wr(CTL, 32'h0000_0041);
    for (int i = 0; i < 8; i++) begin
      if (i == 6) begin
        wr(CTL, 32'h0000_00C1);
      end
      ev(7'(1 << (i % 6)));
      chk(irq, i > 1);
      rd(STA, 32'h0000_0001 << (i % 6));
    end
    td("interrupt");
    apb(1'b0, 24'h00_0000, 32'h0000_0000);
    chk(serr, 1'b1);
    chk(pready, 1'b1);
    td("bus");
    end_of_test;
  end
endmodule // tb_esp_frame_ctrl
`default_nettype wire
